/* File: rtl/amc_mode_ctrl.sv */
// converter mode control register and its sequencing effects
// Operation
// RULE1 - absorb enabled delay into conversion time
// RULE2 - settled-only option drops unsettled single-channel results
// RULE3 - software writes zero to bits 12:11
// RULE4 - wait programmed delay after channel switch
// RULE5 - delay code selects zero to 1 ms
// RULE6 - software writes zero to bit 7
// RULE7 - mode codes continuous, single, standby, power-down
// RULE8 - codes 100, 110, 111 start calibrations
// RULE9 - mode code 101 is reserved
// RULE10 - all fields reset to zero
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/10ps
module amc_mode_ctrl #(
    parameter amc_pkg::amc_cnt_t CYC_40US_P = amc_pkg::CYC_40US,
    parameter amc_pkg::amc_cnt_t CYC_100US_P = amc_pkg::CYC_100US,
    parameter amc_pkg::amc_cnt_t CYC_200US_P = amc_pkg::CYC_200US,
    parameter amc_pkg::amc_cnt_t CYC_500US_P = amc_pkg::CYC_500US,
    parameter amc_pkg::amc_cnt_t CYC_1MS_P = amc_pkg::CYC_1MS
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic [amc_pkg::REG_ADDR_W-1:0] reg_addr_in,
    input wire logic [amc_pkg::REG_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [amc_pkg::REG_DATA_W-1:0] reg_rdata_out,
    input wire logic chan_switch_in,
    input wire logic single_channel_in,
    input wire logic absorb_rate_ok_in,
    input wire logic result_valid_in,
    input wire logic result_settled_in,
    input wire logic cal_done_in,
    output logic process_start_out,
    output logic settle_busy_out,
    output logic result_valid_out,
    output amc_pkg::amc_mode_t op_mode_out,
    output logic mode_reserved_out,
    output logic cal_int_off_start_out,
    output logic cal_sys_off_start_out,
    output logic cal_sys_gain_start_out,
    output logic cal_busy_out
);
    import amc_pkg::*;

    typedef struct packed {
        logic absorb_en;
        logic settled_only;
        logic [2:0] delay;
        amc_mode_t mode;
        logic mode_rsvd;
        logic absorb_act;
        logic proc_start;
        logic res_valid;
        logic [2:0] cal_start;
        logic cal_busy;
        logic [REG_DATA_W-1:0] rdata;
    } amc_ctrl_state_t;

    amc_ctrl_state_t state_reg;
    amc_ctrl_state_t state_next;
    amc_mode_t wr_mode;
    logic wr_mode_hit;
    logic [2:0] cal_hit;

    amc_settle_if settle ();

    function automatic logic is_conv_mode(input amc_mode_t m);
        is_conv_mode = (m == AMC_MODE_CONT) || (m == AMC_MODE_SINGLE);
    endfunction : is_conv_mode

    function automatic logic is_cal_mode(input amc_mode_t m);
        is_cal_mode = (m == AMC_MODE_CAL_INT_OFF) ||
            (m == AMC_MODE_CAL_SYS_OFF) ||
            (m == AMC_MODE_CAL_SYS_GAIN);
    endfunction : is_cal_mode

    function automatic logic [REG_DATA_W-1:0] mode_word(input amc_ctrl_state_t s);
        mode_word = '0;
        mode_word[ABSORB_BIT] = s.absorb_en;
        mode_word[SETTLED_BIT] = s.settled_only;
        mode_word[DELAY_LSB +: FIELD3_W] = s.delay;
        mode_word[MODE_LSB +: FIELD3_W] = s.mode;
    endfunction : mode_word

    function automatic logic [REG_DATA_W-1:0] status_word(input amc_ctrl_state_t s, input logic busy);
        status_word = '0;
        status_word[ST_SETTLE_BIT] = busy;
        status_word[ST_CAL_BIT] = s.cal_busy;
        status_word[ST_ABSORB_BIT] = s.absorb_act;
        // RULE9 - reserved code flagged
        status_word[ST_RSVD_BIT] = s.mode_rsvd;
    endfunction : status_word

    // RULE1 - absorb needs bit, delay and rate
    function automatic logic absorb_now(input amc_ctrl_state_t s, input logic rate_ok);
        absorb_now = s.absorb_en && (s.delay != 3'b000) && rate_ok;
    endfunction : absorb_now

    // RULE2 - unsettled single-channel results dropped
    function automatic logic result_pass(input amc_ctrl_state_t s, input logic single, input logic settled);
        result_pass = !(s.settled_only && single) || settled;
    endfunction : result_pass

    function automatic amc_mode_t cal_lane_mode(input int unsigned lane);
        unique case (lane)
            CAL_INT_OFF_IDX: cal_lane_mode = AMC_MODE_CAL_INT_OFF;
            CAL_SYS_OFF_IDX: cal_lane_mode = AMC_MODE_CAL_SYS_OFF;
            default: cal_lane_mode = AMC_MODE_CAL_SYS_GAIN;
        endcase
    endfunction : cal_lane_mode

    amc_settle_timer #(
        .CYC_40US_P(CYC_40US_P),
        .CYC_100US_P(CYC_100US_P),
        .CYC_200US_P(CYC_200US_P),
        .CYC_500US_P(CYC_500US_P),
        .CYC_1MS_P(CYC_1MS_P)
    ) u_settle_timer (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .tmr(settle.timer)
    );

    // RULE4 - timer started per switch
    assign settle.start = chan_switch_in;
    assign settle.code = state_reg.delay;

    // RULE8 - one start lane per calibration code
    for (genvar g = 0; g < 3; g++) begin : g_cal_lane
        assign cal_hit[g] = wr_mode_hit && (wr_mode == cal_lane_mode(g));
    end

    always_comb begin
        wr_mode_hit = reg_wr_in && (reg_addr_in == MODE_CTRL_OFS);
        wr_mode = amc_mode_t'(reg_wdata_in[MODE_LSB +: FIELD3_W]);
        state_next = state_reg;
        state_next.proc_start = 1'b0;
        state_next.cal_start = 3'b000;
        state_next.rdata = '0;

        // register write; reserved bits are not stored
        if (wr_mode_hit) begin
            // RULE3 - bits 12:11 dropped
            // RULE6 - bit 7 dropped
            state_next.absorb_en = reg_wdata_in[ABSORB_BIT];
            state_next.settled_only = reg_wdata_in[SETTLED_BIT];
            state_next.delay = reg_wdata_in[DELAY_LSB +: FIELD3_W];
            // RULE7 - operating mode select
            state_next.mode = wr_mode;
            // RULE9 - reserved code held in a flop
            state_next.mode_rsvd = (wr_mode == AMC_MODE_RSVD);
        end

        // done clears first so a new start wins
        if (cal_done_in) begin
            state_next.cal_busy = 1'b0;
        end
        // RULE8 - calibration start pulses
        if (wr_mode_hit && is_cal_mode(wr_mode)) begin
            state_next.cal_busy = 1'b1;
            state_next.cal_start = cal_hit;
        end

        // channel switch handling
        if (chan_switch_in) begin
            // RULE1 - absorb needs bit, delay, rate
            state_next.absorb_act = absorb_now(state_reg, absorb_rate_ok_in);
            if (absorb_now(state_reg, absorb_rate_ok_in)) begin
                state_next.proc_start = 1'b1;
            end
        end else if (settle.done && !state_reg.absorb_act) begin
            // RULE4 - processing starts after wait
            state_next.proc_start = 1'b1;
        end

        // results pass only outside the wait, in a conversion mode
        state_next.res_valid = 1'b0;
        // RULE7 - results only in conversion modes
        if (result_valid_in && !settle.busy && !chan_switch_in && is_conv_mode(state_reg.mode)) begin
            // RULE2 - settled results only
            if (result_pass(state_reg, single_channel_in, result_settled_in)) begin
                state_next.res_valid = 1'b1;
            end
        end

        // read data stands in the cycle after the strobe
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                MODE_CTRL_OFS: begin
                    state_next.rdata = mode_word(state_reg);
                end
                STATUS_OFS: begin
                    state_next.rdata = status_word(state_reg, settle.busy);
                end
                default: begin
                    state_next.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // RULE10 - all fields zero
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_out = state_reg.rdata;
    assign process_start_out = state_reg.proc_start;
    assign settle_busy_out = settle.busy;
    assign result_valid_out = state_reg.res_valid;
    assign op_mode_out = state_reg.mode;
    // RULE9 - code 101 reported
    assign mode_reserved_out = state_reg.mode_rsvd;
    assign cal_int_off_start_out = state_reg.cal_start[CAL_INT_OFF_IDX];
    assign cal_sys_off_start_out = state_reg.cal_start[CAL_SYS_OFF_IDX];
    assign cal_sys_gain_start_out = state_reg.cal_start[CAL_SYS_GAIN_IDX];
    assign cal_busy_out = state_reg.cal_busy;

endmodule : amc_mode_ctrl

/* File: rtl/amc_pkg.sv */
// constants and types for the converter mode control block
package amc_pkg;

    // register port
    localparam int unsigned REG_ADDR_W = 4;
    localparam int unsigned REG_DATA_W = 16;
    localparam logic [3:0] MODE_CTRL_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h1;
    localparam logic [15:0] MODE_CTRL_RST = 16'h0000;

    // mode control field positions
    localparam int unsigned ABSORB_BIT = 14;
    localparam int unsigned SETTLED_BIT = 13;
    localparam int unsigned DELAY_LSB = 8;
    localparam int unsigned MODE_LSB = 4;
    localparam int unsigned FIELD3_W = 3;

    // status field positions
    localparam int unsigned ST_SETTLE_BIT = 0;
    localparam int unsigned ST_CAL_BIT = 1;
    localparam int unsigned ST_ABSORB_BIT = 2;
    localparam int unsigned ST_RSVD_BIT = 3;

    // clock and settling delay times
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned DLY_4_US = 4;
    localparam int unsigned DLY_16_US = 16;
    localparam int unsigned DLY_40_US = 40;
    localparam int unsigned DLY_100_US = 100;
    localparam int unsigned DLY_200_US = 200;
    localparam int unsigned DLY_500_US = 500;
    localparam int unsigned DLY_1_MS = 1;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned NS_PER_MS = 1000000;

    localparam int unsigned CNT_W = 17;
    typedef logic [CNT_W-1:0] amc_cnt_t;

    // least waits, rounded up to whole cycles
    localparam amc_cnt_t CYC_4US = amc_cnt_t'((DLY_4_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam amc_cnt_t CYC_16US = amc_cnt_t'((DLY_16_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam amc_cnt_t CYC_40US = amc_cnt_t'((DLY_40_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam amc_cnt_t CYC_100US = amc_cnt_t'((DLY_100_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam amc_cnt_t CYC_200US = amc_cnt_t'((DLY_200_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam amc_cnt_t CYC_500US = amc_cnt_t'((DLY_500_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam amc_cnt_t CYC_1MS = amc_cnt_t'((DLY_1_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        AMC_MODE_CONT = 3'b000,
        AMC_MODE_SINGLE = 3'b001,
        AMC_MODE_STANDBY = 3'b010,
        AMC_MODE_PDOWN = 3'b011,
        AMC_MODE_CAL_INT_OFF = 3'b100,
        AMC_MODE_RSVD = 3'b101,
        AMC_MODE_CAL_SYS_OFF = 3'b110,
        AMC_MODE_CAL_SYS_GAIN = 3'b111
    } amc_mode_t;

    // calibration start pulse lanes
    localparam int unsigned CAL_INT_OFF_IDX = 0;
    localparam int unsigned CAL_SYS_OFF_IDX = 1;
    localparam int unsigned CAL_SYS_GAIN_IDX = 2;

endpackage : amc_pkg

/* File: rtl/amc_settle_if.sv */
// link between the mode control and its settling timer
`timescale 1ns/10ps
interface amc_settle_if;
    logic start;
    logic [2:0] code;
    logic busy;
    logic done;

    modport ctrl (output start, output code, input busy, input done);
    modport timer (input start, input code, output busy, output done);
endinterface : amc_settle_if

/* File: rtl/amc_settle_timer.sv */
// settling delay timer started on each channel switch
`timescale 1ns/10ps
module amc_settle_timer #(
    parameter amc_pkg::amc_cnt_t CYC_40US_P = amc_pkg::CYC_40US,
    parameter amc_pkg::amc_cnt_t CYC_100US_P = amc_pkg::CYC_100US,
    parameter amc_pkg::amc_cnt_t CYC_200US_P = amc_pkg::CYC_200US,
    parameter amc_pkg::amc_cnt_t CYC_500US_P = amc_pkg::CYC_500US,
    parameter amc_pkg::amc_cnt_t CYC_1MS_P = amc_pkg::CYC_1MS
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    amc_settle_if.timer tmr
);
    import amc_pkg::*;

    typedef struct packed {
        amc_cnt_t cnt;
        logic busy;
        logic done;
    } amc_tmr_state_t;

    amc_tmr_state_t state_reg;
    amc_tmr_state_t state_next;
    amc_cnt_t load_cyc;

    // RULE5 - delay code table
    function automatic amc_cnt_t delay_cycles(input logic [2:0] code);
        unique case (code)
            3'b000: delay_cycles = '0;
            3'b001: delay_cycles = CYC_4US;
            3'b010: delay_cycles = CYC_16US;
            3'b011: delay_cycles = CYC_40US_P;
            3'b100: delay_cycles = CYC_100US_P;
            3'b101: delay_cycles = CYC_200US_P;
            3'b110: delay_cycles = CYC_500US_P;
            3'b111: delay_cycles = CYC_1MS_P;
        endcase
    endfunction : delay_cycles

    always_comb begin
        load_cyc = delay_cycles(tmr.code);
        state_next = state_reg;
        state_next.done = 1'b0;
        // RULE4 - restart wait on switch
        if (tmr.start) begin
            if (load_cyc == '0) begin
                state_next.busy = 1'b0;
                state_next.done = 1'b1;
            end else begin
                state_next.cnt = amc_cnt_t'(load_cyc - 1'b1);
                state_next.busy = 1'b1;
            end
        end else if (state_reg.busy) begin
            if (state_reg.cnt == '0) begin
                state_next.busy = 1'b0;
                state_next.done = 1'b1;
            end else begin
                state_next.cnt = amc_cnt_t'(state_reg.cnt - 1'b1);
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tmr.busy = state_reg.busy;
    assign tmr.done = state_reg.done;

endmodule : amc_settle_timer

/* File: bench/amc_mode_ctrl_assertions.sv */
// port checker for the converter mode control block
`timescale 1ns/10ps
module amc_mode_ctrl_checker (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic [amc_pkg::REG_ADDR_W-1:0] reg_addr_in,
    input wire logic [amc_pkg::REG_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [amc_pkg::REG_DATA_W-1:0] reg_rdata_out,
    input wire logic chan_switch_in,
    input wire logic result_valid_in,
    input wire logic settle_busy_out,
    input wire logic result_valid_out,
    input wire amc_pkg::amc_mode_t op_mode_out,
    input wire logic mode_reserved_out,
    input wire logic cal_int_off_start_out,
    input wire logic cal_sys_off_start_out,
    input wire logic cal_sys_gain_start_out,
    input wire logic cal_busy_out
);
    import amc_pkg::*;
    logic mode_wr;
    logic cal_any;
    assign mode_wr = reg_wr_in && reg_addr_in == MODE_CTRL_OFS;
    assign cal_any = cal_int_off_start_out | cal_sys_off_start_out | cal_sys_gain_start_out;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data outside read answer cycle");
    a_mode_write: assert property (mode_wr |=> op_mode_out == $past(reg_wdata_in[6:4]))
        else $error("mode field not taken from write");
    a_mode_hold: assert property (!mode_wr |=> $stable(op_mode_out))
        else $error("mode changed without write");
    a_reserved_flag: assert property (mode_reserved_out == (op_mode_out == AMC_MODE_RSVD))
        else $error("reserved mode flag wrong");
    a_cal_int: assert property (mode_wr && reg_wdata_in[6:4] == 3'h4 |=> cal_int_off_start_out && !cal_sys_off_start_out)
        else $error("internal offset start missing");
    a_cal_sys_off: assert property (mode_wr && reg_wdata_in[6:4] == 3'h6 |=> cal_sys_off_start_out && !cal_sys_gain_start_out)
        else $error("system offset start missing");
    a_cal_sys_gain: assert property (mode_wr && reg_wdata_in[6:4] == 3'h7 |=> cal_sys_gain_start_out && !cal_int_off_start_out)
        else $error("system gain start missing");
    a_cal_cause: assert property (cal_any |-> $past(mode_wr) && cal_busy_out)
        else $error("calibration start without write");
    a_result_cause: assert property (result_valid_out |-> $past(result_valid_in) && !$past(settle_busy_out)
        && !$past(chan_switch_in) && $past(op_mode_out) inside {AMC_MODE_CONT, AMC_MODE_SINGLE})
        else $error("result passed without cause");
endmodule : amc_mode_ctrl_checker

bind amc_mode_ctrl amc_mode_ctrl_checker u_chk (.core_clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .chan_switch_in, .result_valid_in, .settle_busy_out, .result_valid_out, .op_mode_out,
    .mode_reserved_out, .cal_int_off_start_out, .cal_sys_off_start_out, .cal_sys_gain_start_out, .cal_busy_out);

/* File: bench/tb.sv */
// self-checking bench for the converter mode control block
`timescale 1ns/10ps
module tb;
    import amc_pkg::*;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, chan_switch_in = 1'b0, single_channel_in = 1'b0;
    logic absorb_rate_ok_in = 1'b0, result_valid_in = 1'b0, result_settled_in = 1'b0, cal_done_in = 1'b0;
    logic [15:0] reg_rdata_out;
    logic process_start_out, settle_busy_out, result_valid_out, mode_reserved_out, cal_busy_out;
    logic cal_int_off_start_out, cal_sys_off_start_out, cal_sys_gain_start_out;
    amc_mode_t op_mode_out;
    int errors = 0;
    int checks = 0;
    int n;
    logic [15:0] d, q;
    logic b;

    amc_mode_ctrl #(.CYC_40US_P(17'h0000A), .CYC_100US_P(17'h00014), .CYC_200US_P(17'h0001E),
        .CYC_500US_P(17'h00028), .CYC_1MS_P(17'h00032)) dut (.core_clk_in, .reset_n_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .chan_switch_in, .single_channel_in,
        .absorb_rate_ok_in, .result_valid_in, .result_settled_in, .cal_done_in, .process_start_out,
        .settle_busy_out, .result_valid_out, .op_mode_out, .mode_reserved_out, .cal_int_off_start_out,
        .cal_sys_off_start_out, .cal_sys_gain_start_out, .cal_busy_out);

    always #4 core_clk_in = ~core_clk_in;

    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task results;
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    task wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk_in) {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, v, 1'b1};
        @(posedge core_clk_in) reg_wr_in <= 1'b0;
        #1;
    endtask : wr_reg

    task rd_reg(input logic [3:0] a, output logic [15:0] v);
        @(posedge core_clk_in) {reg_addr_in, reg_rd_in} <= {a, 1'b1};
        @(posedge core_clk_in) reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask : rd_reg

    task pulse(input bit sel);
        @(posedge core_clk_in) begin
            if (sel) begin
                cal_done_in <= 1'b1;
            end else begin
                chan_switch_in <= 1'b1;
            end
        end
        @(posedge core_clk_in) {chan_switch_in, cal_done_in} <= 2'b00;
        #1;
    endtask : pulse

    // cycles from switch edge to processing start
    task do_switch(output int k);
        pulse(1'b0);
        k = 1;
        while (process_start_out !== 1'b1 && k < 3000) begin
            @(posedge core_clk_in);
            #1 k++;
        end
        if (k >= 3000) begin
            errors++;
            results();
        end
    endtask : do_switch

    task pass_result(input logic s, output logic v);
        @(posedge core_clk_in) {result_valid_in, result_settled_in} <= {1'b1, s};
        @(posedge core_clk_in) result_valid_in <= 1'b0;
        #1 v = result_valid_out;
    endtask : pass_result

    function automatic int exp_wait(input int code);
        int tbl[8] = '{0, 500, 2000, 10, 20, 30, 40, 50};
        return tbl[code] + 2;
    endfunction : exp_wait

    initial begin
        #400000;
        errors++;
        results();
    end

    initial begin
        d = 16'($urandom(261));
        repeat (6) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        rd_reg(MODE_CTRL_OFS, d);
        check(d, MODE_CTRL_RST);
        rd_reg(4'hF, d);
        check(d, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr_reg(MODE_CTRL_OFS, {9'h000, 3'(i), 4'h0});
            check(16'(op_mode_out), 16'(i));
            check({cal_int_off_start_out, cal_sys_off_start_out, cal_sys_gain_start_out}, {i == 4, i == 6, i == 7});
            check(16'(mode_reserved_out), 16'(i == 5));
            if (i == 4 || i == 6 || i == 7) begin
                check(16'(cal_busy_out), 16'h0001);
                pulse(1'b1);
                check(16'(cal_busy_out), 16'h0000);
            end
        end
        // unstored bits dropped on write
        repeat (8) begin
            d = 16'($urandom) & 16'hE77F;
            wr_reg(MODE_CTRL_OFS, d);
            rd_reg(MODE_CTRL_OFS, q);
            check(q, d & 16'h6770);
        end
        // clear any calibration the random writes left busy
        pulse(1'b1);
        for (int i = 0; i < 8; i++) begin
            wr_reg(MODE_CTRL_OFS, {5'h00, 3'(i), 8'h00});
            do_switch(n);
            check(16'(n), 16'(exp_wait(i)));
        end
        @(posedge core_clk_in) absorb_rate_ok_in <= 1'b1;
        wr_reg(MODE_CTRL_OFS, 16'h4300);
        do_switch(n);
        check(16'(n), 16'h0001);
        rd_reg(STATUS_OFS, q);
        check(q, 16'h0005);
        repeat (20) @(posedge core_clk_in);
        absorb_rate_ok_in <= 1'b0;
        do_switch(n);
        check(16'(n), 16'h000C);
        @(posedge core_clk_in) single_channel_in <= 1'b1;
        wr_reg(MODE_CTRL_OFS, 16'h2000);
        pass_result(1'b0, b);
        check(16'(b), 16'h0000);
        pass_result(1'b1, b);
        check(16'(b), 16'h0001);
        wr_reg(MODE_CTRL_OFS, 16'h0300);
        pass_result(1'b0, b);
        check(16'(b), 16'h0001);
        pulse(1'b0);
        check(16'(settle_busy_out), 16'h0001);
        rd_reg(STATUS_OFS, q);
        check(q, 16'h0001);
        pass_result(1'b1, b);
        check(16'(b), 16'h0000);
        repeat (20) @(posedge core_clk_in);
        #1 check(16'(settle_busy_out), 16'h0000);
        wr_reg(MODE_CTRL_OFS, 16'h0020);
        pass_result(1'b1, b);
        check(16'(b), 16'h0000);
        @(posedge core_clk_in) reset_n_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        rd_reg(MODE_CTRL_OFS, d);
        check(d, 16'h0000);
        results();
    end
endmodule : tb
